// >>> rtl/samc_pkg.sv
/*
 * Shared constants and types for the sleep and airplane mode controller.
 * Assumes a single 10 MHz clock and a synchronous active-high reset.
 */
package samc_pkg;

    // =========================================================================
    // Clock and timing
    // =========================================================================
    localparam int unsigned CLK_HZ        = 10000000;
    localparam int unsigned WAKE_PULSE_US = 1;
    localparam int unsigned WAKE_PULSE_CYC =
        (WAKE_PULSE_US * (CLK_HZ / 1000000) > 0) ? WAKE_PULSE_US * (CLK_HZ / 1000000) : 1;

    // =========================================================================
    // APB register offsets (byte addresses)
    // =========================================================================
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_SUPPLY = 8'h08;

    // =========================================================================
    // Control register fields
    // =========================================================================
    localparam int unsigned CTRL_SLEEP_EN   = 0;
    localparam int unsigned CTRL_SENSE_POL  = 1;
    localparam int unsigned CTRL_RADIO_PIN  = 2;
    localparam int unsigned CTRL_LEVEL_LSB  = 4;
    localparam int unsigned CTRL_PATH_LSB   = 8;
    localparam int unsigned CTRL_REPORT     = 12;
    localparam int unsigned CTRL_POWER_DOWN = 13;
    localparam int unsigned CTRL_RADIO_CMD  = 14;

    // =========================================================================
    // Reset values and encodings
    // =========================================================================
    localparam logic [2:0] LEVEL_MIN      = 3'h0;
    localparam logic [2:0] LEVEL_FULL     = 3'h1;
    localparam logic [2:0] LEVEL_AIRPLANE = 3'h4;

    typedef enum logic [1:0] {
        PATH_UART    = 2'b00,
        PATH_USB_RWK = 2'b01,
        PATH_USB_RI  = 2'b10,
        PATH_USB_VB  = 2'b11
    } samc_path_t;

    typedef enum logic [2:0] {
        ST_NORMAL  = 3'b000,
        ST_SLEEP   = 3'b001,
        ST_MINFUNC = 3'b010,
        ST_AIRPL   = 3'b011,
        ST_DOWN    = 3'b100
    } samc_state_t;

endpackage

// >>> rtl/samc_link_if.sv
/*
 * Pins between the module end and the host end.
 * Assumes both ends share clk; the bench joins them through this interface.
 */
`timescale 1ns/1ps
interface samc_link_if;
    logic dtr;          // Host drives, high allows sleep
    logic radioOff_n;   // Radio-disable pin, pulled up when undriven
    logic hostSleep;    // Host sleep sense, polarity configured
    logic vbus;         // USB bus power from host
    logic usbSuspend;   // Host bus in suspend
    logic usbData;      // Host sends data over USB
    logic ring;         // Ring indicator to host
    logic remoteWake;   // USB remote wake signalling

    modport dev  (input dtr, radioOff_n, hostSleep, vbus, usbSuspend, usbData,
                  output ring, remoteWake);
    modport host (output dtr, radioOff_n, hostSleep, vbus, usbSuspend, usbData,
                  input ring, remoteWake);
endinterface

// >>> rtl/samc_device.sv
/*
 * Module end: mode controller deciding sleep, minimum function, airplane
 * and power-down, with wake signalling to the host.
 * Assumes link pins are asynchronous and pass three flip-flops each.
 */
// Chosen here: the register addresses and the APB interface to the registers.
//
// Operation
// - UART sleep needs enable and DTR high
// - DTR low wakes the module
// - Pending report asserts ring on UART (here only while host sense reads asleep)
// - Host sense sampled with configurable polarity
// - USB sleep needs enable, DTR high, suspend
// - USB data from host wakes module
// - Remote wake signalled when host supports it
// - Without remote wake, ring wakes host
// - VBUS removal allows sleep, restore wakes
// - Airplane disables radio, rejects radio commands
// - Radio-disable pin low selects airplane mode
// - Radio pin control off until enabled
// - Levels 0, 1 default, 4 accepted
// - Level changes leave positioning untouched
// - Minimum function disables radio and SIM
// - Sleep keeps network reception alive
// - Power-down cuts internal supply and interface
// - Host cuts supply only after shutdown
// - Baseband supply reported on query
`timescale 1ns/1ps
module samc_device (
    input  wire logic                 clk,
    input  wire logic                 srst,
    samc_link_if.dev                  link,
    input  wire logic [7:0]           paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [11:0]          supplyLevel,
    output logic                      radioOn,
    output logic                      simOn,
    output logic                      gnssOn,
    output logic                      asleep,
    output logic                      coreOn,
    output logic                      serialOn,
    output logic                      rxAlive
);
    import samc_pkg::*;

    // =========================================================================
    // State
    // =========================================================================
    typedef struct packed {
        logic [2:0]  dtrS;
        logic [2:0]  radS;
        logic [2:0]  senS;
        logic [2:0]  vbS;
        logic [2:0]  susS;
        logic [2:0]  datS;
        logic        dtr;
        logic        radOff_n;
        logic        sense;
        logic        vbus;
        logic        susp;
        logic        data;
        logic        sleepEn;
        logic        sensePol;
        logic        radioPinEn;
        logic [2:0]  level;
        samc_path_t  path;
        logic        report;
        logic        powerDown;
        logic        cmdReject;
        samc_state_t st;
        logic        ring;
        logic        rwake;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        radioOn;
        logic        simOn;
        logic        asleep;
        logic        coreOn;
    } samc_dev_t;

    samc_dev_t r;
    samc_dev_t next_r;

    // Filtered level follows only when second and third stage agree
    function automatic logic settle(input logic [2:0] s, input logic prev);
        settle = (s[1] == s[2]) ? s[2] : prev;
    endfunction

    logic hostAsleep;
    logic sleepOk;
    logic wake;
    logic radioPinAir;

    always_comb begin
        next_r = r;
        // Three-stage synchronisers; stage 0 feeds only stage 1
        next_r.dtrS = {r.dtrS[1:0], link.dtr};
        next_r.radS = {r.radS[1:0], link.radioOff_n};
        next_r.senS = {r.senS[1:0], link.hostSleep};
        next_r.vbS  = {r.vbS[1:0],  link.vbus};
        next_r.susS = {r.susS[1:0], link.usbSuspend};
        next_r.datS = {r.datS[1:0], link.usbData};
        next_r.dtr      = settle(r.dtrS, r.dtr);
        next_r.radOff_n = settle(r.radS, r.radOff_n);
        next_r.sense    = settle(r.senS, r.sense);
        next_r.vbus     = settle(r.vbS, r.vbus);
        next_r.susp     = settle(r.susS, r.susp);
        next_r.data     = settle(r.datS, r.data);

        hostAsleep  = r.sense ^ r.sensePol;
        radioPinAir = r.radioPinEn && !r.radOff_n;

        // Preconditions of the selected host path, all at once
        case (r.path)
            PATH_UART: sleepOk = r.sleepEn && r.dtr;
            PATH_USB_VB: sleepOk = r.sleepEn && r.dtr && !r.vbus;
            default: sleepOk = r.sleepEn && r.dtr && r.susp;
        endcase
        // Any wake condition of the path
        case (r.path)
            PATH_UART: wake = !r.dtr;
            PATH_USB_VB: wake = !r.dtr || r.vbus;
            default: wake = !r.dtr || r.data || !r.susp;
        endcase

        // Mode sequencing; power-down is final until reset
        case (r.st)
            ST_DOWN: next_r.st = ST_DOWN;
            default: begin
                if (r.powerDown) begin
                    next_r.st = ST_DOWN;
                end else if (r.level == LEVEL_MIN) begin
                    next_r.st = ST_MINFUNC;
                end else if (r.level == LEVEL_AIRPLANE || radioPinAir) begin
                    next_r.st = ST_AIRPL;
                end else if (r.st == ST_SLEEP) begin
                    next_r.st = wake ? ST_NORMAL : ST_SLEEP;
                end else begin
                    next_r.st = (sleepOk && !wake) ? ST_SLEEP : ST_NORMAL;
                end
            end
        endcase

        // Host wake signalling for a pending report
        next_r.ring  = 1'b0;
        next_r.rwake = 1'b0;
        if (r.report && r.st != ST_DOWN) begin
            if (r.path == PATH_USB_RWK) begin
                next_r.rwake = r.susp;
            end else begin
                next_r.ring = (r.path == PATH_UART) ? hostAsleep : 1'b1;
            end
        end

        next_r.radioOn = (next_r.st == ST_NORMAL) || (next_r.st == ST_SLEEP);
        next_r.simOn   = (next_r.st != ST_MINFUNC) && (next_r.st != ST_DOWN);
        next_r.asleep  = (next_r.st == ST_SLEEP);
        next_r.coreOn  = (next_r.st != ST_DOWN);

        // APB slave, one wait-free access phase
        next_r.pready  = 1'b0;
        next_r.pslverr = 1'b0;
        if (psel && !penable && r.st != ST_DOWN) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0;
            case (paddr)
                OFF_CTRL: begin
                    if (pwrite) begin
                        next_r.sleepEn    = pwdata[CTRL_SLEEP_EN];
                        next_r.sensePol   = pwdata[CTRL_SENSE_POL];
                        next_r.radioPinEn = pwdata[CTRL_RADIO_PIN];
                        // Only levels 0, 1 and 4 are taken; others are refused
                        if (pwdata[CTRL_LEVEL_LSB +: 3] == LEVEL_MIN
                            || pwdata[CTRL_LEVEL_LSB +: 3] == LEVEL_FULL
                            || pwdata[CTRL_LEVEL_LSB +: 3] == LEVEL_AIRPLANE) begin
                            next_r.level = pwdata[CTRL_LEVEL_LSB +: 3];
                        end else begin
                            next_r.pslverr = 1'b1;
                        end
                        next_r.path      = samc_path_t'(pwdata[CTRL_PATH_LSB +: 2]);
                        next_r.report    = pwdata[CTRL_REPORT];
                        next_r.powerDown = pwdata[CTRL_POWER_DOWN];
                        // Radio-dependent command refused without radio
                        if (pwdata[CTRL_RADIO_CMD] && !r.radioOn) begin
                            next_r.cmdReject = 1'b1;
                            next_r.pslverr   = 1'b1;
                        end
                    end else begin
                        // Read-back mirrors the write layout, except the radio command bit, which reads 0
                        next_r.prdata = {18'h0, r.powerDown, r.report, 2'b0,
                                         2'(r.path), 1'b0, r.level, 1'b0,
                                         r.radioPinEn, r.sensePol, r.sleepEn};
                    end
                end
                OFF_STATUS: begin
                    if (!pwrite) begin
                        next_r.prdata = {22'h0, r.cmdReject, hostAsleep, r.radOff_n,
                                         r.vbus, r.susp, r.dtr, 1'b0, 3'(r.st)};
                        next_r.cmdReject = 1'b0;  // Cleared by reading
                    end
                end
                OFF_SUPPLY: begin
                    if (!pwrite) begin
                        next_r.prdata = {20'h0, supplyLevel};
                    end
                end
                default: next_r.pslverr = 1'b1;
            endcase
        end
    end

    // =========================================================================
    // Register update
    // =========================================================================
    always_ff @(posedge clk) begin
        if (srst) begin
            r            <= '0;
            r.dtrS       <= 3'h7;
            r.radS       <= 3'h7;
            r.dtr        <= 1'b1;
            r.radOff_n   <= 1'b1;
            r.level      <= LEVEL_FULL;
            r.path       <= PATH_UART;
            r.st         <= ST_NORMAL;
            r.radioOn    <= 1'b1;
            r.simOn      <= 1'b1;
            r.coreOn     <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign link.ring       = r.ring;
    assign link.remoteWake = r.rwake;
    assign prdata   = r.prdata;
    assign pready   = r.pready;
    assign pslverr  = r.pslverr;
    assign radioOn  = r.radioOn;
    assign simOn    = r.simOn;
    assign gnssOn   = r.coreOn;
    assign asleep   = r.asleep;
    assign coreOn   = r.coreOn;
    assign serialOn = r.coreOn;
    assign rxAlive  = r.radioOn;
endmodule

// >>> rtl/samc_host.sv
/*
 * Host end: drives the sleep and wake pins from user commands and reports
 * wake requests from the module.
 * Assumes ring and remote wake arrive asynchronously.
 */
`timescale 1ns/1ps
module samc_host (
    input  wire logic clk,
    input  wire logic srst,
    samc_link_if.host link,
    input  wire logic allowSleep,
    input  wire logic airplane,
    input  wire logic hostSleeping,
    input  wire logic busSuspend,
    input  wire logic sendData,
    input  wire logic busPower,
    input  wire logic moduleDown,
    input  wire logic cutSupply,
    output logic      wakeReq,
    output logic      supplyOn
);
    import samc_pkg::*;

    // =========================================================================
    // State
    // =========================================================================
    typedef struct packed {
        logic [2:0] ringS;
        logic [2:0] rwS;
        logic       dtr;
        logic       radOff_n;
        logic       sense;
        logic       vbus;
        logic       susp;
        logic       data;
        logic       wake;
        logic       supply;
    } samc_host_t;

    samc_host_t r;
    samc_host_t next_r;

    always_comb begin
        next_r = r;
        next_r.ringS    = {r.ringS[1:0], link.ring};
        next_r.rwS      = {r.rwS[1:0], link.remoteWake};
        next_r.dtr      = allowSleep;
        next_r.radOff_n = !airplane;
        next_r.sense    = hostSleeping;
        next_r.susp     = busSuspend;
        next_r.data     = sendData;
        next_r.vbus     = busPower;
        // Wake only when both late stages agree the line is high
        next_r.wake = (r.ringS[1] && r.ringS[2]) || (r.rwS[1] && r.rwS[2]);
        // Supply held until the module has shut down
        if (cutSupply && moduleDown) begin
            next_r.supply = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r          <= '0;
            r.dtr      <= 1'b1;
            r.radOff_n <= 1'b1;
            r.vbus     <= 1'b1;
            r.supply   <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign link.dtr        = r.dtr;
    assign link.radioOff_n = r.radOff_n;
    assign link.hostSleep  = r.sense;
    assign link.vbus       = r.vbus;
    assign link.usbSuspend = r.susp;
    assign link.usbData    = r.data;
    assign wakeReq  = r.wake;
    assign supplyOn = r.supply;
endmodule

// >>> test/samc_link_asserts.sv
/* Checker for the pins between the module end and the host end.
 * Assumes the bench clock and reset; instantiated beside the link. */
`timescale 1ns/1ps
module samc_link_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire logic dtr,
    input wire logic radioOff_n,
    input wire logic hostSleep,
    input wire logic vbus,
    input wire logic usbSuspend,
    input wire logic usbData,
    input wire logic ring,
    input wire logic remoteWake
);
    // =====================================================================
    // Sequences
    // =====================================================================
    // First edge after reset is released
    sequence s_released;
        $fell(srst);
    endsequence
    // Eight quiet cycles let the pin synchroniser drain
    sequence s_resumed;
        !usbSuspend [*8];
    endsequence
    // Two low samples after a suspended bus resumes
    sequence s_bus_resumed;
        $fell(usbSuspend) ##1 !usbSuspend;
    endsequence

    // =====================================================================
    // Properties
    // =====================================================================
    // Host pins idle: DTR high, radio pin pulled up, bus powered
    AST_HOST_IDLE: assert property (@(posedge clk) disable iff (srst)
        s_released |-> dtr && radioOff_n && vbus && !usbSuspend && !usbData && !hostSleep)
        else $error("host pins not idle after reset");
    // No wake request leaves the module straight out of reset
    AST_DEV_IDLE: assert property (@(posedge clk) disable iff (srst)
        s_released |-> !ring && !remoteWake)
        else $error("wake pins not idle after reset");
    // One wake method at a time, chosen by the host path
    AST_WAKE_EXCL: assert property (@(posedge clk) disable iff (srst)
        remoteWake |-> !ring)
        else $error("ring and remote wake together");
    // Bus signalling only while the host bus is suspended
    AST_REMOTE_SUSPEND: assert property (@(posedge clk) disable iff (srst)
        s_resumed |-> !remoteWake)
        else $error("remote wake without suspend");
    // Remote wake rises only after the bus was seen suspended
    AST_REMOTE_RISE: assert property (@(posedge clk) disable iff (srst)
        $rose(remoteWake) |-> $past(usbSuspend, 4))
        else $error("remote wake rose without suspend");
    // Resume stops remote wake once the pin filter has followed
    AST_REMOTE_DROP: assert property (@(posedge clk) disable iff (srst)
        s_bus_resumed |-> ##4 !remoteWake)
        else $error("remote wake kept after resume");
endmodule

// >>> test/testbench.sv
/* Self-checking bench joining both ends through the link interface.
 * Assumes a 10 MHz clock and synchronous active-high reset. */
`timescale 1ns/1ps
module testbench;
    import samc_pkg::*;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [11:0] supplyLevel;
    logic        radioOn, simOn, gnssOn, asleep, coreOn, serialOn, rxAlive;
    logic        allowSleep, airplane, hostSleeping, busSuspend, sendData;
    logic        busPower, moduleDown, cutSupply, wakeReq, supplyOn;
    int          n_fail = 0;
    int          checks_done = 0;
    int          i;
    logic [2:0]  lv [4];
    logic [2:0]  bad [5] = '{3'h2, 3'h3, 3'h5, 3'h6, 3'h7};

    // =====================================================================
    // Both ends and the checker
    // =====================================================================
    samc_link_if link_a ();
    samc_device samc_device_inst (.clk(clk), .srst(srst), .link(link_a),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supplyLevel(supplyLevel), .radioOn(radioOn), .simOn(simOn),
        .gnssOn(gnssOn), .asleep(asleep), .coreOn(coreOn),
        .serialOn(serialOn), .rxAlive(rxAlive));
    samc_host samc_host_inst (.clk(clk), .srst(srst), .link(link_a),
        .allowSleep(allowSleep), .airplane(airplane),
        .hostSleeping(hostSleeping), .busSuspend(busSuspend),
        .sendData(sendData), .busPower(busPower), .moduleDown(moduleDown),
        .cutSupply(cutSupply), .wakeReq(wakeReq), .supplyOn(supplyOn));
    samc_link_asserts samc_link_asserts_inst (.clk(clk), .srst(srst),
        .dtr(link_a.dtr), .radioOff_n(link_a.radioOff_n),
        .hostSleep(link_a.hostSleep), .vbus(link_a.vbus),
        .usbSuspend(link_a.usbSuspend), .usbData(link_a.usbData),
        .ring(link_a.ring), .remoteWake(link_a.remoteWake));

    // =====================================================================
    // Helpers
    // =====================================================================
    // Free-running 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] ctrl(logic s, logic p, logic r, logic [2:0] l,
                                         logic [1:0] pa, logic u);
        logic [31:0] w;
        w = 32'h0;
        w[CTRL_SLEEP_EN] = s;
        w[CTRL_SENSE_POL] = p;
        w[CTRL_RADIO_PIN] = r;
        w[CTRL_LEVEL_LSB +: 3] = l;
        w[CTRL_PATH_LSB +: 2] = pa;
        w[CTRL_REPORT] = u;
        return w;
    endfunction

    function automatic samc_state_t st_of(logic [2:0] l);
        return (l == LEVEL_MIN) ? ST_MINFUNC : (l == LEVEL_AIRPLANE) ? ST_AIRPL : ST_NORMAL;
    endfunction

    // Radio, SIM, positioning expected per level; positioning never drops
    function automatic logic [2:0] fn_of(logic [2:0] l);
        return {l == LEVEL_FULL, l != LEVEL_MIN, 1'b1};
    endfunction

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; held until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pin changes need a few cycles through the synchronisers
    task settle;
        repeat (10) @(posedge clk);
    endtask

    task end_of_test;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        end_of_test;
    end

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        void'($urandom(32'h18207918));
        srst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        supplyLevel = 12'($urandom);
        {allowSleep, airplane, hostSleeping, busSuspend, sendData} = '0;
        {moduleDown, cutSupply} = '0;
        busPower = 1'b1;
        lv = '{LEVEL_MIN, LEVEL_FULL, LEVEL_AIRPLANE, bad[$urandom % 5]};
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        settle;
        apb(0, OFF_CTRL, 0);
        chk("ctrl", q, ctrl(0, 0, 0, LEVEL_FULL, PATH_UART, 0));
        apb(0, OFF_STATUS, 0);
        chk("status", q & 32'h0C7, 32'h0C0);
        chk("outs", 32'({radioOn, simOn, gnssOn, coreOn, asleep}), 32'h1E);
        apb(0, 8'h0C, 0);
        chk("unmapped", 32'(e), 32'h1);
        apb(1, OFF_SUPPLY, 32'hFFF);
        apb(0, OFF_SUPPLY, 0);
        chk("supply", q, 32'(supplyLevel));
        $display("test regs done");
        for (i = 0; i < 4; i++) begin
            apb(1, OFF_CTRL, ctrl(0, 0, 0, lv[i], PATH_UART, 0));
            chk("lverr", 32'(e), 32'(i == 3));
            apb(0, OFF_STATUS, 0);
            chk("state", q & 32'h7, 32'(st_of(lv[(i == 3) ? 2 : i])));
            chk("func", 32'({radioOn, simOn, gnssOn}), 32'(fn_of(lv[(i == 3) ? 2 : i])));
        end
        $display("test levels done");
        airplane <= 1'b1;
        apb(1, OFF_CTRL, ctrl(0, 0, 0, LEVEL_FULL, PATH_UART, 0));
        settle;
        apb(0, OFF_STATUS, 0);
        chk("pinoff", q & 32'h7, 32'(ST_NORMAL));
        apb(1, OFF_CTRL, ctrl(0, 0, 1, LEVEL_FULL, PATH_UART, 0));
        apb(0, OFF_STATUS, 0);
        chk("pinon", q & 32'h7, 32'(ST_AIRPL));
        apb(1, OFF_CTRL, ctrl(0, 0, 1, LEVEL_FULL, PATH_UART, 0) | (32'h1 << CTRL_RADIO_CMD));
        chk("rejerr", 32'({e, radioOn}), 32'h2);
        apb(0, OFF_STATUS, 0);
        chk("rej", q & 32'h200, 32'h200);
        apb(0, OFF_STATUS, 0);
        chk("rejclr", q & 32'h200, 32'h0);
        airplane <= 1'b0;
        $display("test airplane done");
        allowSleep <= 1'b1;
        apb(1, OFF_CTRL, ctrl(0, 0, 0, LEVEL_FULL, PATH_UART, 0));
        settle;
        chk("noslp", 32'(asleep), 32'h0);
        apb(1, OFF_CTRL, ctrl(1, 0, 0, LEVEL_FULL, PATH_UART, 0) | (32'h1 << CTRL_RADIO_CMD));
        chk("cmdok", 32'(e), 32'h0);
        settle;
        chk("slp", 32'({asleep, rxAlive}), 32'h3);
        allowSleep <= 1'b0;
        settle;
        chk("dtrwake", 32'(asleep), 32'h0);
        hostSleeping <= 1'b1;
        apb(1, OFF_CTRL, ctrl(0, 0, 0, LEVEL_FULL, PATH_UART, 1));
        settle;
        chk("ring", 32'({link_a.ring, wakeReq}), 32'h3);
        apb(1, OFF_CTRL, ctrl(0, 1, 0, LEVEL_FULL, PATH_UART, 1));
        settle;
        chk("pol", 32'(link_a.ring), 32'h0);
        hostSleeping <= 1'b0;
        settle;
        chk("polinv", 32'(link_a.ring), 32'h1);
        $display("test uart done");
        for (i = 1; i < 4; i++) begin
            allowSleep <= 1'b1;
            busSuspend <= (i != 3);
            busPower <= (i != 3);
            apb(1, OFF_CTRL, ctrl(1, 0, 0, LEVEL_FULL, 2'(i), 1));
            apb(0, OFF_CTRL, 0);
            chk("ctrlrd", q, ctrl(1, 0, 0, LEVEL_FULL, 2'(i), 1));
            settle;
            chk("usbslp", 32'(asleep), 32'h1);
            if (i < 3) begin
                chk("wake", 32'({link_a.remoteWake, link_a.ring}), (i == 1) ? 32'h2 : 32'h1);
            end
            sendData <= (i != 3);
            busPower <= 1'b1;
            settle;
            chk("usbwake", 32'(asleep), 32'h0);
            {sendData, busSuspend, allowSleep} <= 3'h0;
            settle;
        end
        $display("test usb done");
        cutSupply <= 1'b1;
        apb(1, OFF_CTRL, ctrl(0, 0, 0, LEVEL_FULL, PATH_UART, 0) | (32'h1 << CTRL_POWER_DOWN));
        settle;
        chk("down", 32'({coreOn, serialOn, supplyOn}), 32'h1);
        moduleDown <= 1'b1;
        settle;
        chk("cut", 32'(supplyOn), 32'h0);
        $display("test power done");
        end_of_test;
    end
endmodule
